// >>> core/acq_qual_pkg.sv
// shared constants of the acquisition storage qualifier
package acq_qual_pkg;
  // ----------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_GQMASK = 8'h04;
  localparam logic [7:0] ADR_SCMD = 8'h08;
  localparam logic [7:0] ADR_DETMASK = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_WRCNT = 8'h14;
  localparam logic [7:0] ADR_HRIDX = 8'h18;
  localparam logic [7:0] ADR_HRDATA = 8'h1C;
  localparam logic [7:0] ADR_DIV = 8'h20;
  // ----------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------
  localparam int CTRL_GQ_EN = 0;
  localparam int CTRL_INIT_ON = 1;
  localparam int CTRL_BLOCK = 2;
  localparam int CTRL_GLITCH = 3;
  localparam int CTRL_SHV = 4;
  localparam int CTRL_TRANS = 5;
  localparam int CTRL_START = 6;
  localparam int CTRL_STOP = 7;
  localparam int CTRL_HIRES = 8;
  localparam int ST_RUN = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_TRANS_ALL = 2;
  localparam int ST_FREE_LSB = 8;
  // ----------------------------------------------------------
  // reset values and command codes
  // ----------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h00000002;
  localparam logic [31:0] GQMASK_RST = 32'h00000000;
  localparam logic [31:0] SCMD_RST = 32'h00000000;
  localparam logic [31:0] DETMASK_RST = 32'h00000000;
  localparam logic [31:0] DIV_RST = 32'h00000000;
  localparam logic [1:0] CMD_ON = 2'h1;
  localparam logic [1:0] CMD_OFF = 2'h2;
  // ----------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------
  localparam int BLOCK_SPAN = 31;
  localparam int HIRES_DEPTH = 2016;
  localparam int WORD_RECOG = 16;
  localparam int CLK_PERIOD_PS = 50000;
  localparam int GLITCH_MIN_PERIOD_NS = 10;
  localparam int GLITCH_MIN_RAW =
    (GLITCH_MIN_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GLITCH_MIN_CYC = (GLITCH_MIN_RAW < 1) ? 1 : GLITCH_MIN_RAW;
  localparam int HIRES_PERIOD_PS = 500;
  localparam int HIRES_RAW = HIRES_PERIOD_PS / CLK_PERIOD_PS;
  localparam int HIRES_CYC = (HIRES_RAW < 1) ? 1 : HIRES_RAW;
endpackage : acq_qual_pkg

// >>> core/acq_storage_qualifier.sv
// storage qualifier between probe samples and acquisition memory
// Behaviour
// - global condition gates storage when enabled
// - state storage command overrides global qualifier
// - selectable initial storage state, default on
// - events switch storage for current sample only
// - event decision overrides every global command
// - block mode stores 31 samples each side
// - block refused with glitch or violation storage
// - glitch information optionally stored with samples
// - glitch mode splits word: data and violations
// - glitch mode sample period at least 10ns
// - each detector consumes one word recognizer
// - all-group transition mode stores changed samples
// - high resolution memory holds 2016 samples
// - high resolution memory samples fixed independent
// - transition compares against previous valid sample
`timescale 1ns/1ps
`default_nettype none
module acq_storage_qualifier #(
  parameter int CH_W = 32,
  parameter int GROUPS = 4,
  parameter int MEM_AW = 12,
  parameter int HR_DEPTH = acq_qual_pkg::HIRES_DEPTH,
  parameter int SPAN = acq_qual_pkg::BLOCK_SPAN
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // probe pins
  input wire logic [CH_W-1:0] probe_i,
  input wire logic [CH_W/2-1:0] viol_i,
  // trigger machine
  input wire logic [3:0] trig_state_i,
  input wire logic [15:0] trig_res_i,
  input wire logic evt_on_i,
  input wire logic evt_off_i,
  // acquisition memory write port
  output logic mem_we_o,
  output logic [MEM_AW-1:0] mem_addr_o,
  output logic [CH_W-1:0] mem_data_o
);
  localparam int H = CH_W / 2;
  localparam int GW = CH_W / GROUPS;
  localparam int HRW = $clog2(HR_DEPTH);
  localparam int PW = CH_W + H;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [PW-1:0] s1_q, s2_q, s3_q, pv_q;
  // a change counts only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pv_q <= '0;
    end else begin
      s1_q <= {viol_i, probe_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) pv_q <= s3_q;
    end
  end
  logic [CH_W-1:0] cur;
  logic [H-1:0] vcur;
  assign cur = pv_q[CH_W-1:0];
  assign vcur = pv_q[PW-1:CH_W];

  // ----------------------------------------------------------
  // register file and bus slave
  // ----------------------------------------------------------
  logic ack_q, ack_d, refused_q, refused_d, start_p, stop_p, run_q;
  logic [31:0] rdat_q, rdat_d, ctrl_q, ctrl_d, gqm_q, gqm_d, scmd_q;
  logic [31:0] scmd_d, detm_q, detm_d, div_q, div_d, wrcnt_q, wmask;
  logic [HRW-1:0] hridx_q, hridx_d;
  logic [7:0] adr_w;
  logic wr_take;
  logic [4:0] used, free_n;
  logic trans_all;
  logic [CH_W-1:0] hr_mem [HR_DEPTH];

  assign adr_w = {wb_adr_i[7:2], 2'b00};
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // a write lands on the edge where the master sees ack
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign trans_all = ctrl_q[acq_qual_pkg::CTRL_TRANS]
                   & (&detm_q[GROUPS-1:0]);

  always_comb begin : used_c
    logic [4:0] acc;
    logic [4:0] kinds;
    acc = '0;
    kinds = 5'(ctrl_q[acq_qual_pkg::CTRL_GLITCH])
          + 5'(ctrl_q[acq_qual_pkg::CTRL_SHV])
          + 5'(ctrl_q[acq_qual_pkg::CTRL_TRANS]);
    for (int g = 0; g < GROUPS; g++) begin
      if (detm_q[g]) acc = acc + kinds;
    end
    used = acc;
    free_n = (acc > 5'(acq_qual_pkg::WORD_RECOG)) ? 5'h00
           : 5'(acq_qual_pkg::WORD_RECOG) - acc;
  end

  // register decode, read mux and write effects
  always_comb begin : bus_c
    logic [31:0] nv;
    logic ref_set, ref_clr;
    nv = (ctrl_q & ~wmask) | (wb_dat_i & wmask);
    ref_set = 1'b0;
    ref_clr = 1'b0;
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    gqm_d = gqm_q;
    scmd_d = scmd_q;
    detm_d = detm_q;
    div_d = div_q;
    hridx_d = hridx_q;
    start_p = 1'b0;
    stop_p = 1'b0;
    if (ack_d) begin
      case (adr_w)
        acq_qual_pkg::ADR_CTRL: rdat_d = ctrl_q;
        acq_qual_pkg::ADR_GQMASK: rdat_d = gqm_q;
        acq_qual_pkg::ADR_SCMD: rdat_d = scmd_q;
        acq_qual_pkg::ADR_DETMASK: rdat_d = detm_q;
        acq_qual_pkg::ADR_STATUS: begin
          rdat_d = '0;
          rdat_d[acq_qual_pkg::ST_RUN] = run_q;
          rdat_d[acq_qual_pkg::ST_REFUSED] = refused_q;
          rdat_d[acq_qual_pkg::ST_TRANS_ALL] = trans_all;
          rdat_d[acq_qual_pkg::ST_FREE_LSB +: 5] = free_n;
        end
        acq_qual_pkg::ADR_WRCNT: rdat_d = wrcnt_q;
        acq_qual_pkg::ADR_HRIDX: rdat_d = 32'(hridx_q);
        acq_qual_pkg::ADR_HRDATA: rdat_d = 32'(hr_mem[hridx_q]);
        acq_qual_pkg::ADR_DIV: rdat_d = div_q;
        default: rdat_d = '0;
      endcase
    end
    if (wr_take) begin
      case (adr_w)
        acq_qual_pkg::ADR_CTRL: begin
          if (nv[acq_qual_pkg::CTRL_BLOCK] &
              (nv[acq_qual_pkg::CTRL_GLITCH] | nv[acq_qual_pkg::CTRL_SHV]))
          begin
            nv[acq_qual_pkg::CTRL_BLOCK] = 1'b0;
            ref_set = 1'b1;
          end
          start_p = nv[acq_qual_pkg::CTRL_START];
          stop_p = nv[acq_qual_pkg::CTRL_STOP];
          nv[acq_qual_pkg::CTRL_START] = 1'b0;
          nv[acq_qual_pkg::CTRL_STOP] = 1'b0;
          ctrl_d = nv;
        end
        acq_qual_pkg::ADR_GQMASK:
          gqm_d = (gqm_q & ~wmask) | (wb_dat_i & wmask);
        acq_qual_pkg::ADR_SCMD:
          scmd_d = (scmd_q & ~wmask) | (wb_dat_i & wmask);
        acq_qual_pkg::ADR_DETMASK:
          detm_d = (detm_q & ~wmask) | (wb_dat_i & wmask);
        acq_qual_pkg::ADR_STATUS:
          ref_clr = wb_sel_i[0] & wb_dat_i[acq_qual_pkg::ST_REFUSED];
        acq_qual_pkg::ADR_HRIDX:
          hridx_d = HRW'(((32'(hridx_q) & ~wmask) | (wb_dat_i & wmask)));
        acq_qual_pkg::ADR_DIV:
          div_d = (div_q & ~wmask) | (wb_dat_i & wmask);
        default: ;
      endcase
    end
    // a refusal in the clearing cycle is kept
    refused_d = ref_set | (refused_q & ~ref_clr);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= acq_qual_pkg::CTRL_RST;
      gqm_q <= acq_qual_pkg::GQMASK_RST;
      scmd_q <= acq_qual_pkg::SCMD_RST;
      detm_q <= acq_qual_pkg::DETMASK_RST;
      div_q <= acq_qual_pkg::DIV_RST;
      hridx_q <= '0;
      refused_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      gqm_q <= gqm_d;
      scmd_q <= scmd_d;
      detm_q <= detm_d;
      div_q <= div_d;
      hridx_q <= hridx_d;
      refused_q <= refused_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // block never coexists with violation storage
  block_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_q[acq_qual_pkg::CTRL_BLOCK] |->
    !(ctrl_q[acq_qual_pkg::CTRL_GLITCH] | ctrl_q[acq_qual_pkg::CTRL_SHV]))
    else $error("block storage enabled with violation storage");

  // ----------------------------------------------------------
  // sample qualification and memory write
  // ----------------------------------------------------------
  logic first_q, first_d, run_d, we_q, we_d, samp_en, blk, glitch;
  logic [7:0] cnt_q, cnt_d, eff_div;
  logic [CH_W-1:0] prev_q, prev_d, data_q, data_d, word;
  logic [MEM_AW-1:0] addr_q, addr_d;
  logic [31:0] wrcnt_d;
  logic [SPAN-1:0][CH_W-1:0] dly_q, dly_d;
  logic [2*SPAN-1:0] qh_q, qh_d;
  logic [GROUPS-1:0] gdiff;
  logic cond, glob, dec;
  logic [1:0] cmd;

  // per-group difference against previous valid sample
  for (genvar g = 0; g < GROUPS; g++) begin : grp_g
    assign gdiff[g] = |(cur[g*GW +: GW] ^ prev_q[g*GW +: GW]);
  end

  assign blk = ctrl_q[acq_qual_pkg::CTRL_BLOCK];
  assign glitch = ctrl_q[acq_qual_pkg::CTRL_GLITCH];
  // glitch storage forces the slower sample period
  assign eff_div = (glitch &&
    div_q[7:0] < 8'(acq_qual_pkg::GLITCH_MIN_CYC - 1))
    ? 8'(acq_qual_pkg::GLITCH_MIN_CYC - 1) : div_q[7:0];
  assign samp_en = run_q & (cnt_q == 8'h00);
  // condition over trigger resources, counters never feed it
  assign cond = (gqm_q[15:0] != 16'h0000)
              & ((trig_res_i & gqm_q[15:0]) == gqm_q[15:0]);
  assign cmd = scmd_q[{trig_state_i, 1'b0} +: 2];
  // violation bits replace the upper data half
  assign word = glitch ? {vcur, cur[H-1:0]} : cur;

  always_comb begin : qual_c
    // first sample after start uses initial state
    glob = ctrl_q[acq_qual_pkg::CTRL_GQ_EN]
         ? (first_q ? ctrl_q[acq_qual_pkg::CTRL_INIT_ON] : cond) : 1'b1;
    if (trans_all && !first_q && !(|(gdiff & detm_q[GROUPS-1:0])))
      glob = 1'b0;
    dec = glob;
    // active state command wins over global
    if (cmd == acq_qual_pkg::CMD_ON) dec = 1'b1;
    else if (cmd == acq_qual_pkg::CMD_OFF) dec = 1'b0;
    if (evt_off_i) dec = 1'b0;
    else if (evt_on_i) dec = 1'b1;
    run_d = start_p | (run_q & ~stop_p);
    cnt_d = (!run_q) ? 8'h00 : (samp_en ? eff_div : cnt_q - 8'h01);
    first_d = first_q;
    prev_d = prev_q;
    dly_d = dly_q;
    qh_d = qh_q;
    we_d = 1'b0;
    data_d = data_q;
    // address moves only past a written word
    addr_d = addr_q + MEM_AW'(we_q);
    wrcnt_d = wrcnt_q + 32'(we_q);
    if (start_p) begin
      first_d = 1'b1;
      addr_d = '0;
      wrcnt_d = '0;
      qh_d = '0;
    end else if (samp_en) begin
      first_d = 1'b0;
      prev_d = cur;
      dly_d = {dly_q[SPAN-2:0], word};
      qh_d = {qh_q[2*SPAN-2:0], dec};
      // delayed sample kept when any of 63 qualified
      we_d = blk ? (dec | (|qh_q)) : dec;
      data_d = blk ? dly_q[SPAN-1] : word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      first_q <= 1'b1;
      prev_q <= '0;
      dly_q <= '0;
      qh_q <= '0;
      we_q <= 1'b0;
      data_q <= '0;
      addr_q <= '0;
      wrcnt_q <= '0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      prev_q <= prev_d;
      dly_q <= dly_d;
      qh_q <= qh_d;
      we_q <= we_d;
      data_q <= data_d;
      addr_q <= addr_d;
      wrcnt_q <= wrcnt_d;
    end
  end
  assign mem_we_o = we_q;
  assign mem_addr_o = addr_q;
  assign mem_data_o = data_q;

  addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!mem_we_o && !start_p) |=> $stable(mem_addr_o))
    else $error("address moved without a write");
  evt_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !start_p && !blk && evt_on_i && !evt_off_i) |=> mem_we_o)
    else $error("store event did not write");
  evt_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !blk && evt_off_i) |=> !mem_we_o)
    else $error("off event still wrote");
  state_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !blk && !evt_on_i && !evt_off_i &&
     cmd == acq_qual_pkg::CMD_OFF) |=> !mem_we_o)
    else $error("state off command ignored");
  glob_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !blk && !evt_on_i && !evt_off_i && cmd == 2'h0 &&
     ctrl_q[acq_qual_pkg::CTRL_GQ_EN] && !first_q && !cond)
    |=> !mem_we_o)
    else $error("global condition false but stored");
  init_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !start_p && !blk && first_q && !evt_on_i && !evt_off_i &&
     cmd == 2'h0 && ctrl_q[acq_qual_pkg::CTRL_GQ_EN])
    |=> mem_we_o == $past(ctrl_q[acq_qual_pkg::CTRL_INIT_ON]))
    else $error("initial storage state not applied");
  trans_rep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !blk && trans_all && !first_q && cur == prev_q &&
     !evt_on_i && !evt_off_i && cmd == 2'h0) |=> !mem_we_o)
    else $error("unchanged sample stored");
  glitch_pack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && !start_p && glitch && !blk) |=>
    (mem_data_o[CH_W-1:H] == $past(vcur)
      && mem_data_o[H-1:0] == $past(cur[H-1:0])))
    else $error("glitch word layout wrong");
  glitch_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en && glitch) |=> (cnt_q == $past(eff_div)))
    else $error("glitch sample period too short");

  // ----------------------------------------------------------
  // high resolution capture, free running
  // ----------------------------------------------------------
  logic [HRW-1:0] hr_wp_q, hr_wp_d;
  logic [7:0] hr_cnt_q, hr_cnt_d;
  logic hr_tick;
  // limitation: the fine period collapses to one clock here
  assign hr_tick = ctrl_q[acq_qual_pkg::CTRL_HIRES] & (hr_cnt_q == 8'h00);

  // fixed-period ring, independent of the main run
  always_comb begin : hr_c
    hr_cnt_d = (hr_cnt_q == 8'h00)
      ? 8'(acq_qual_pkg::HIRES_CYC - 1) : hr_cnt_q - 8'h01;
    hr_wp_d = hr_wp_q;
    if (hr_tick)
      hr_wp_d = (hr_wp_q == HRW'(HR_DEPTH - 1)) ? '0 : hr_wp_q + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hr_wp_q <= '0;
      hr_cnt_q <= 8'h00;
    end else begin
      hr_wp_q <= hr_wp_d;
      hr_cnt_q <= hr_cnt_d;
    end
  end
  // memory array has no reset
  always_ff @(posedge clk_i) begin
    if (hr_tick) hr_mem[hr_wp_q] <= cur;
  end

  hr_depth_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hr_tick && hr_wp_q == HRW'(HR_DEPTH - 1) |=> hr_wp_q == '0)
    else $error("high resolution ring did not wrap");
  hr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (hr_tick && hr_wp_q != HRW'(HR_DEPTH - 1)) |=>
    hr_wp_q == $past(hr_wp_q) + 1'b1)
    else $error("high resolution write pointer stalled");
  recog_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[acq_qual_pkg::CTRL_GLITCH] && !ctrl_q[acq_qual_pkg::CTRL_SHV]
     && !ctrl_q[acq_qual_pkg::CTRL_TRANS] && detm_q[GROUPS-1:0] == '1)
    |-> used == 5'(GROUPS))
    else $error("recognizer usage miscounted");
endmodule : acq_storage_qualifier
`default_nettype wire

// >>> sim/acq_target_model.sv
// far-side model: probed target pins and acquisition memory
`timescale 1ns/1ps
`default_nettype none
module acq_target_model (
  // clock and bench control
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [31:0] pat_i,
  // probe pins
  output logic [31:0] probe_o,
  output logic [15:0] viol_o,
  // memory write port and what it received
  input wire logic mem_we_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic [31:0] mem_data_i,
  output logic [31:0] count_o,
  output logic [31:0] data_o,
  output logic addr_bad_o
);
  // --------------------------------------------------------
  // target pins
  // --------------------------------------------------------
  // violation bits invert the low data half so swapped halves show
  assign probe_o = pat_i;
  assign viol_o = ~pat_i[15:0];
  // --------------------------------------------------------
  // memory side
  // --------------------------------------------------------
  // count stored words, keep the last one
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      count_o <= 32'h0;
      addr_bad_o <= 1'b0;
    end else if (mem_we_i) begin
      count_o <= count_o + 32'h1;
      data_o <= mem_data_i;
      if (mem_addr_i !== count_o[11:0]) begin
        addr_bad_o <= 1'b1;
      end
    end
  end
endmodule : acq_target_model
`default_nettype wire

// >>> sim/acquisition_storage_qualifier_test.sv
// self-checking bench of the acquisition storage qualifier
`timescale 1ns/1ps
`default_nettype none
module acquisition_storage_qualifier_test;
  // --------------------------------------------------------
  // config bits and bench state
  // --------------------------------------------------------
  // short block span keeps runs brief
  localparam int SPAN_T = 4;
  localparam logic [31:0] GQ = 32'h1 << acq_qual_pkg::CTRL_GQ_EN;
  localparam logic [31:0] INI = 32'h1 << acq_qual_pkg::CTRL_INIT_ON;
  localparam logic [31:0] BLK = 32'h1 << acq_qual_pkg::CTRL_BLOCK;
  localparam logic [31:0] GLI = 32'h1 << acq_qual_pkg::CTRL_GLITCH;
  localparam logic [31:0] SHV = 32'h1 << acq_qual_pkg::CTRL_SHV;
  localparam logic [31:0] TRN = 32'h1 << acq_qual_pkg::CTRL_TRANS;
  localparam logic [31:0] STA = 32'h1 << acq_qual_pkg::CTRL_START;
  localparam logic [31:0] STP = 32'h1 << acq_qual_pkg::CTRL_STOP;
  localparam logic [31:0] HIR = 32'h1 << acq_qual_pkg::CTRL_HIRES;
  localparam logic [31:0] REF = 32'h1 << acq_qual_pkg::ST_REFUSED;
  logic clk_i, rst_i, cyc, stb, we, ack, evt_on, evt_off, mem_we, clr, abad;
  logic [7:0] adr;
  logic [3:0] sel, tstate;
  logic [15:0] viol, tres;
  logic [11:0] mem_addr;
  logic [31:0] dat_w, dat_r, probe, mem_data, pat, mcount, mdata, q, m, r;
  logic [7:0] zregs [4] = '{8'h04, 8'h08, 8'h0C, 8'h20};
  int err_count, comparisons, i, s;
  integer seed;
  // --------------------------------------------------------
  // design and far side
  // --------------------------------------------------------
  acq_storage_qualifier #(.SPAN(SPAN_T)) u_acq_storage_qualifier (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .probe_i(probe), .viol_i(viol),
    .trig_state_i(tstate), .trig_res_i(tres), .evt_on_i(evt_on),
    .evt_off_i(evt_off), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_data_o(mem_data));
  acq_target_model u_acq_target_model (
    .clk_i(clk_i), .clr_i(clr), .pat_i(pat), .probe_o(probe),
    .viol_o(viol), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
    .mem_data_i(mem_data), .count_o(mcount), .data_o(mdata),
    .addr_bad_o(abad));
  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // --------------------------------------------------------
  // tasks
  // --------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask : wb
  // start, optional one-cycle event and pattern change, stop, count
  task automatic run(input logic [31:0] cfg, input int k, input logic pon,
                     input logic [31:0] np, output logic [31:0] cnt);
    logic [31:0] d;
    clr <= 1'b1;
    wb(1'b1, acq_qual_pkg::ADR_CTRL, cfg | STA, d);
    clr <= 1'b0;
    repeat (k) @(posedge clk_i);
    evt_on <= pon;
    pat <= np;
    @(posedge clk_i);
    evt_on <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(1'b1, acq_qual_pkg::ADR_CTRL, cfg | STP, d);
    repeat (4) @(posedge clk_i);
    wb(1'b0, acq_qual_pkg::ADR_WRCNT, 32'h0, cnt);
    check(cnt, mcount);
    check({31'h0, abad}, 32'h0);
  endtask : run
  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    seed = 32'h7788;
    err_count = 0;
    comparisons = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    tstate = 4'h0;
    tres = 16'h0;
    evt_on = 1'b0;
    evt_off = 1'b0;
    clr = 1'b1;
    pat = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values; unmapped place reads zero
    wb(1'b0, acq_qual_pkg::ADR_CTRL, 32'h0, q);
    check(q, acq_qual_pkg::CTRL_RST);
    wb(1'b1, 8'hFC, 32'hFFFFFFFF, q);
    foreach (zregs[i]) begin
      wb(1'b0, zregs[i], 32'h0, q);
      check(q, 32'h0);
    end
    wb(1'b0, 8'hFC, 32'h0, q);
    check(q, 32'h0);
    $display("reset values done");
    // block refused beside glitch or violation storage
    for (i = 0; i < 2; i++) begin
      wb(1'b1, acq_qual_pkg::ADR_CTRL, BLK | (i[0] ? SHV : GLI), q);
      wb(1'b0, acq_qual_pkg::ADR_CTRL, 32'h0, q);
      check(q & BLK, 32'h0);
      wb(1'b0, acq_qual_pkg::ADR_STATUS, 32'h0, q);
      check(q & REF, REF);
      wb(1'b1, acq_qual_pkg::ADR_STATUS, REF, q);
    end
    $display("block refusal done");
    // initial state: global condition never met, resource bit0 held low
    wb(1'b1, acq_qual_pkg::ADR_GQMASK, 32'h1, q);
    run(GQ | INI, 5, 1'b0, pat, q);
    check(q, 32'h1);
    run(GQ, 5, 1'b0, pat, q);
    check(q, 32'h0);
    $display("initial storage state done");
    // random global masks, matched and unmatched
    for (i = 0; i < 4; i++) begin
      m = $random(seed) | 32'h1;
      r = $random(seed);
      tres <= i[0] ? (m[15:0] | r[15:0]) : (r[15:0] & 16'hFFFE);
      wb(1'b1, acq_qual_pkg::ADR_GQMASK, {16'h0, m[15:0]}, q);
      run(GQ, 5, 1'b0, pat, q);
      check({31'h0, q != 32'h0}, {31'h0, i[0]});
    end
    tres <= 16'h0;
    wb(1'b1, acq_qual_pkg::ADR_GQMASK, 32'h1, q);
    $display("global qualifier done");
    // state command beats the global qualifier both ways
    s = {$random(seed)} % 16;
    tstate <= s[3:0];
    wb(1'b1, acq_qual_pkg::ADR_SCMD, 32'(acq_qual_pkg::CMD_ON) << (2 * s), q);
    run(GQ, 5, 1'b0, pat, q);
    check({31'h0, q != 32'h0}, 32'h1);
    wb(1'b1, acq_qual_pkg::ADR_SCMD, 32'(acq_qual_pkg::CMD_OFF) << (2 * s), q);
    run(32'h0, 5, 1'b0, pat, q);
    check(q, 32'h0);
    wb(1'b1, acq_qual_pkg::ADR_SCMD, 32'h0, q);
    // off event against storing global and an on event
    evt_off <= 1'b1;
    run(32'h0, 5, 1'b1, pat, q);
    check(q, 32'h0);
    evt_off <= 1'b0;
    $display("state command and event done");
    // single on event stores one word, plain and split
    for (i = 0; i < 2; i++) begin
      r = $random(seed);
      pat <= r;
      run(GQ | (i[0] ? GLI : 32'h0), 10, 1'b1, r, q);
      check(q, 32'h1);
      check(mdata, i[0] ? {~r[15:0], r[15:0]} : r);
    end
    $display("event and glitch word done");
    // block around one valid sample
    run(GQ | BLK, 10, 1'b1, pat, q);
    check(q, 32'(2 * SPAN_T + 1));
    $display("block storage done");
    // transitional storage on all groups
    wb(1'b1, acq_qual_pkg::ADR_DETMASK, 32'hF, q);
    run(TRN, 10, 1'b0, pat, q);
    check(q, 32'h1);
    run(TRN, 10, 1'b0, ~pat, q);
    check(q, 32'h2);
    wb(1'b0, acq_qual_pkg::ADR_STATUS, 32'h0, q);
    check({26'h0, q[12:8], q[2]},
          {26'h0, 5'(acq_qual_pkg::WORD_RECOG - 4), 1'h1});
    // divider slows sampling: one sample every fourth cycle
    wb(1'b1, acq_qual_pkg::ADR_DIV, 32'h3, q);
    run(GLI, 6, 1'b0, pat, q);
    check(q, 32'h8);
    wb(1'b0, acq_qual_pkg::ADR_STATUS, 32'h0, q);
    check({27'h0, q[12:8]},
          {27'h0, 5'(acq_qual_pkg::WORD_RECOG - 4)});
    wb(1'b1, acq_qual_pkg::ADR_DIV, 32'h0, q);
    $display("transition storage done");
    // fine memory fills with no acquisition running
    r = $random(seed);
    pat <= r;
    wb(1'b1, acq_qual_pkg::ADR_CTRL, HIR, q);
    repeat (acq_qual_pkg::HIRES_DEPTH + 100) @(posedge clk_i);
    for (i = 0; i < 2; i++) begin
      wb(1'b1, acq_qual_pkg::ADR_HRIDX,
         i[0] ? 32'(acq_qual_pkg::HIRES_DEPTH - 1) : 32'h0, q);
      wb(1'b0, acq_qual_pkg::ADR_HRDATA, 32'h0, q);
      check(q, r);
    end
    $display("fine memory done");
    print_verdict();
  end
endmodule : acquisition_storage_qualifier_test
`default_nettype wire
